/* File: core/dscs_pkg.sv */
// package for the drive speed command selector: encodings, ranges and timing constants
// assumes a 25 MHz control clock; frequencies are in 0.1 Hz units, currents in 0.1 mA units
`default_nettype none

package dscs_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned FW = 12;
	localparam int unsigned AW = 10;
	localparam logic [AW-1:0] AI_FULL = 10'h3FF;
	localparam logic [7:0] MA20_TENTHS = 8'hC8;
	localparam logic [7:0] MA4_TENTHS = 8'h28;
	// setpoint capture qualification
	localparam int unsigned CAPTURE_MS = 100;
	localparam int unsigned CAPTURE_CYC = (CLK_HZ / 1000) * CAPTURE_MS;
	// jog: 0.2..10 Hz, default 5 Hz; duty cycle 0.2..10 s, default 0.5 s; here the duty cycle is fixed at JOG_GAP_MS
	localparam logic [FW-1:0] JOG_MIN = 12'h002;
	localparam logic [FW-1:0] JOG_MAX = 12'h064;
	localparam logic [FW-1:0] JOG_DEF = 12'h032;
	localparam int unsigned JOG_GAP_MS = 500;
	localparam int unsigned JOG_GAP_CYC = (CLK_HZ / 1000) * JOG_GAP_MS;
	// presets 0.1..400 Hz, defaults 5, 10, 15 Hz
	localparam logic [FW-1:0] PRESET_MIN = 12'h001;
	localparam logic [FW-1:0] PRESET_MAX = 12'hFA0;
	localparam logic [FW-1:0] PRESET1_DEF = 12'h032;
	localparam logic [FW-1:0] PRESET2_DEF = 12'h064;
	localparam logic [FW-1:0] PRESET3_DEF = 12'h096;
	// +/- speed ramp step period
	localparam int unsigned RAMP_STEP_CYC = 2500;
	localparam logic [FW-1:0] FREQ_STEP = 12'h001;
	localparam logic [FW-1:0] FREQ_ZERO = 12'h000;
	// function of the two assignable inputs
	typedef enum logic [2:0] {
		DSCS_FN_NONE, DSCS_FN_REVERSE, DSCS_FN_JOG, DSCS_FN_SPEED_UP, DSCS_FN_SPEED_DOWN,
		DSCS_FN_CAPTURE, DSCS_FN_PRESET, DSCS_FN_STOP
	} dscs_fn_e;
	typedef enum logic [1:0] {DSCS_MA_0_20, DSCS_MA_4_20, DSCS_MA_20_4, DSCS_MA_X_20} dscs_range_e;
	// stop methods ranked lowest to highest
	typedef enum logic [1:0] {DSCS_STOP_NONE, DSCS_STOP_DC, DSCS_STOP_FAST, DSCS_STOP_FREE} dscs_stop_e;
endpackage

`default_nettype wire

/* File: core/dscs_sync.sv */
// two-stage synchroniser for a bank of logic inputs
// assumes inputs may change at any time with respect to sys_clk
`default_nettype none

module dscs_sync #(
	parameter int unsigned W = 4
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_reg;
	// first stage only feeds the second stage
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= '0;
			dout <= '0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule // dscs_sync

`default_nettype wire

/* File: core/dscs_top.sv */
// drive speed command selector: run direction, target frequency and stop request
// assumes analog inputs are already digitised and steady over a cycle; ramps are outside
`default_nettype none

// Overview of operation
// - reverse input runs reverse: level in two-wire, edge-latched in three-wire until forward or enable drop
// - forward and reverse together: forward wins
// - jog speed 0.2..10 Hz default 5; duty cycle spaces jog pulses
// - two-wire: enable and direction high, jog speed while jog input high
// - three-wire: enable high, jog speed while jog button held
// - during jog, fastest safe ramp requested automatically
// - speed-up input raises frequency at accel rate to reference, then holds
// - speed-down input lowers frequency at decel rate to low speed, then holds
// - both speed inputs high: decrease wins
// - memory keeps last speed across stops; without it start from zero
// - capture input high 0.1 s samples analog reference as setpoint
// - setpoint held until next capture or direction command removed
// - preset inputs select reference, preset one, two or three
// - presets 0.1..400 Hz ascending, defaults 5/10/15, clamped to high speed
// - current range 0-20, 4-20, 20-4 or x-20 mA, default 4-20
// - x-20 range scales input over 20 mA; below x gives low speed
// - references summed and limited to high speed; auto/manual uses one
// - inversion subtracts current; clamp gives low speed, else reverses
// - auto/manual input high selects reference two, low reference one
// - auto-run input is extra two-wire run, only in auto mode
// - stop input has programmable level, active only in terminal mode
// - threshold stop decelerates to threshold then starts stop method
// - first stop method holds unless later one ranks higher; input wins ties
// - input one is run enable, input two run forward, three and four assignable
module dscs_top import dscs_pkg::*; (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic run_enable_input,
	input wire logic run_forward_input,
	input wire logic assignable_input_a,
	input wire logic assignable_input_b,
	input wire logic auto_run_input,
	input wire logic [AW-1:0] voltage_reference_input,
	input wire logic [AW-1:0] current_reference_input,
	input wire logic three_wire_cfg,
	input wire logic keypad_mode_cfg,
	input wire dscs_fn_e func_a_cfg,
	input wire dscs_fn_e func_b_cfg,
	input wire logic three_presets_cfg,
	input wire logic updown_memory_cfg,
	input wire logic auto_manual_en_cfg,
	input wire logic ref1_is_current_cfg,
	input wire dscs_range_e current_range_cfg,
	input wire logic [7:0] current_x_cfg,
	input wire logic invert_current_cfg,
	input wire logic clamp_sum_cfg,
	input wire logic stop_active_high_cfg,
	input wire logic thresh_stop_en_cfg,
	input wire logic [FW-1:0] thresh_freq_cfg,
	input wire dscs_stop_e input_stop_type_cfg,
	input wire dscs_stop_e thresh_stop_type_cfg,
	input wire logic [FW-1:0] jog_speed_cfg,
	input wire logic [FW-1:0] preset1_cfg,
	input wire logic [FW-1:0] preset2_cfg,
	input wire logic [FW-1:0] preset3_cfg,
	input wire logic [FW-1:0] low_speed_cfg,
	input wire logic [FW-1:0] high_speed_cfg,
	input wire logic [FW-1:0] output_freq,
	output logic run_cmd,
	output logic reverse_dir,
	output logic [FW-1:0] target_freq,
	output logic jog_active,
	output logic fast_ramp_req,
	output dscs_stop_e stop_method,
	output logic stop_req
);
	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	logic [4:0] li_s;
	dscs_sync #(.W(5)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.din({auto_run_input, assignable_input_b, assignable_input_a, run_forward_input,
			run_enable_input}),
		.dout(li_s)
	);
	logic en_s, fwd_s, ia_s, ib_s, arun_s;
	assign {arun_s, ib_s, ia_s, fwd_s, en_s} = li_s;

	function automatic logic fn_level(input dscs_fn_e f, input dscs_fn_e fa, input dscs_fn_e fb,
		input logic a, input logic b);
		fn_level = (fa == f && a) || (fb == f && b);
	endfunction
	function automatic logic [FW-1:0] clamp_hi(input logic [FW:0] v, input logic [FW-1:0] hi);
		clamp_hi = (v > {1'b0, hi}) ? hi : v[FW-1:0];
	endfunction

	logic rev_l, jog_l, up_l, dn_l, cap_l, stop_l, pre_a, pre_b;
	assign rev_l = fn_level(DSCS_FN_REVERSE, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign jog_l = fn_level(DSCS_FN_JOG, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign up_l = fn_level(DSCS_FN_SPEED_UP, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign dn_l = fn_level(DSCS_FN_SPEED_DOWN, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign cap_l = fn_level(DSCS_FN_CAPTURE, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign stop_l = fn_level(DSCS_FN_STOP, func_a_cfg, func_b_cfg, ia_s, ib_s);
	assign pre_a = (func_a_cfg == DSCS_FN_PRESET) && ia_s;
	assign pre_b = (func_b_cfg == DSCS_FN_PRESET) && ib_s;

	// ------------------------------------------------------------
	// run direction
	// ------------------------------------------------------------
	logic rev_d_reg, rev3_reg, auto_mode;
	assign auto_mode = auto_manual_en_cfg && arun_s;
	// auto mode input: the auto-run pin doubles as mode select when the function is on
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rev_d_reg <= 1'b0;
			rev3_reg <= 1'b0;
		end else begin
			rev_d_reg <= rev_l;
			if (!en_s || fwd_s)
				rev3_reg <= 1'b0;
			else if (rev_l && !rev_d_reg)
				rev3_reg <= 1'b1;
		end
	end
	logic rev_req, fwd_req, dir_req;
	assign rev_req = three_wire_cfg ? rev3_reg : rev_l;
	assign fwd_req = fwd_s || (auto_mode && arun_s);
	assign dir_req = fwd_req || rev_req;

	// ------------------------------------------------------------
	// jog with minimum spacing between pulses
	// ------------------------------------------------------------
	logic [24:0] jog_gap_reg;
	logic jog_ok, jog_prev_reg;
	assign jog_ok = en_s && jog_l && (three_wire_cfg || dir_req);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			jog_gap_reg <= '0;
			jog_prev_reg <= 1'b0;
		end else begin
			jog_prev_reg <= jog_ok && (jog_prev_reg || jog_gap_reg == '0);
			if (jog_prev_reg && !jog_ok)
				jog_gap_reg <= 25'(JOG_GAP_CYC);
			else if (jog_gap_reg != '0)
				jog_gap_reg <= jog_gap_reg - 25'd1;
		end
	end
	logic [FW-1:0] jog_spd;
	assign jog_spd = (jog_speed_cfg < JOG_MIN) ? JOG_MIN :
		(jog_speed_cfg > JOG_MAX) ? JOG_MAX : jog_speed_cfg;

	// ------------------------------------------------------------
	// analog reference scaling
	// ------------------------------------------------------------
	logic [7:0] lo_ma;
	assign lo_ma = (current_range_cfg == DSCS_MA_0_20) ? 8'h00 :
		(current_range_cfg == DSCS_MA_X_20) ? current_x_cfg : MA4_TENTHS;
	logic [FW-1:0] span;
	logic [FW+AW-1:0] v_prod, i_prod;
	logic [FW-1:0] v_ref, i_ref;
	logic [7:0] ma;
	// full scale is AI_FULL, not a power of two, so a shift would never reach high speed
	assign span = high_speed_cfg - low_speed_cfg;
	assign ma = 8'((18'(current_reference_input) * 18'(MA20_TENTHS)) / 18'(AI_FULL));
	assign v_prod = 22'(span) * 22'(voltage_reference_input);
	assign i_prod = 22'(span) * 22'(current_reference_input);
	assign v_ref = low_speed_cfg + FW'(v_prod / 22'(AI_FULL));
	assign i_ref = (ma < lo_ma) ? low_speed_cfg :
		(current_range_cfg == DSCS_MA_20_4) ? high_speed_cfg - FW'(i_prod / 22'(AI_FULL)) :
		low_speed_cfg + FW'(i_prod / 22'(AI_FULL));
	// summing uses the span parts only, so low speed is not counted twice
	logic [FW:0] sum_v;
	logic neg_sum;
	logic [FW-1:0] ref_f;
	assign neg_sum = invert_current_cfg && (i_ref > v_ref);
	always_comb begin
		sum_v = {1'b0, low_speed_cfg};
		if (auto_manual_en_cfg)
			sum_v = {1'b0, (auto_mode ^ ref1_is_current_cfg) ? i_ref : v_ref};
		else if (!invert_current_cfg)
			sum_v = {1'b0, v_ref} + {1'b0, i_ref - low_speed_cfg};
		else if (neg_sum && !clamp_sum_cfg)
			sum_v = {1'b0, low_speed_cfg} + {1'b0, i_ref - v_ref};
		else if (!neg_sum && v_ref != i_ref)
			sum_v = {1'b0, low_speed_cfg} + {1'b0, v_ref - i_ref};
	end
	assign ref_f = clamp_hi(sum_v, high_speed_cfg);

	// ------------------------------------------------------------
	// setpoint capture
	// ------------------------------------------------------------
	logic [21:0] cap_cnt_reg;
	logic [FW-1:0] setpt_reg;
	logic setpt_valid_reg;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cap_cnt_reg <= '0;
			setpt_reg <= FREQ_ZERO;
			setpt_valid_reg <= 1'b0;
		end else begin
			if (!cap_l)
				cap_cnt_reg <= '0;
			else if (cap_cnt_reg != 22'(CAPTURE_CYC))
				cap_cnt_reg <= cap_cnt_reg + 22'd1;
			if (cap_l && cap_cnt_reg == 22'(CAPTURE_CYC - 1)) begin
				setpt_reg <= ref_f;
				setpt_valid_reg <= 1'b1;
			end else if (!dir_req)
				setpt_valid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// +/- speed
	// ------------------------------------------------------------
	logic [11:0] step_cnt_reg;
	logic [FW-1:0] ud_reg;
	logic run_d_reg;
	logic ud_mode;
	assign ud_mode = (func_a_cfg == DSCS_FN_SPEED_UP) || (func_b_cfg == DSCS_FN_SPEED_UP);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			step_cnt_reg <= '0;
			ud_reg <= FREQ_ZERO;
			run_d_reg <= 1'b0;
		end else begin
			run_d_reg <= run_cmd;
			step_cnt_reg <= (step_cnt_reg == 12'(RAMP_STEP_CYC - 1)) ? '0 : step_cnt_reg + 12'd1;
			if (run_cmd && !run_d_reg && !updown_memory_cfg)
				ud_reg <= FREQ_ZERO;
			else if (step_cnt_reg == '0 && run_cmd) begin
				if (dn_l && ud_reg > low_speed_cfg)
					ud_reg <= ud_reg - FREQ_STEP;
				else if (!dn_l && up_l && ud_reg < ref_f)
					ud_reg <= ud_reg + FREQ_STEP;
			end
		end
	end

	// ------------------------------------------------------------
	// preset selection and target
	// ------------------------------------------------------------
	logic [FW-1:0] preset_f, p1, p2, p3, tgt_next;
	// keep presets ascending and in range
	assign p1 = (preset1_cfg < PRESET_MIN) ? PRESET_MIN :
		(preset1_cfg > PRESET_MAX) ? PRESET_MAX : preset1_cfg;
	assign p2 = (preset2_cfg < p1) ? p1 : (preset2_cfg > PRESET_MAX) ? PRESET_MAX : preset2_cfg;
	assign p3 = (preset3_cfg < p2) ? p2 : (preset3_cfg > PRESET_MAX) ? PRESET_MAX : preset3_cfg;
	always_comb begin
		if (!three_presets_cfg)
			preset_f = (pre_a || pre_b) ? p1 : ref_f;
		else
			case ({pre_b, pre_a})
			2'b01: preset_f = p1;
			2'b10: preset_f = p2;
			2'b11: preset_f = p3;
			default: preset_f = ref_f;
			endcase
	end
	always_comb begin
		if (jog_prev_reg)
			tgt_next = jog_spd;
		else if (ud_mode)
			tgt_next = ud_reg;
		else if (setpt_valid_reg)
			tgt_next = setpt_reg;
		else
			tgt_next = clamp_hi({1'b0, preset_f}, high_speed_cfg);
	end

	// ------------------------------------------------------------
	// controlled stop
	// ------------------------------------------------------------
	logic stop_in_act, thr_hit;
	assign stop_in_act = !keypad_mode_cfg && (stop_l == stop_active_high_cfg) &&
		(func_a_cfg == DSCS_FN_STOP || func_b_cfg == DSCS_FN_STOP);
	assign thr_hit = thresh_stop_en_cfg && !dir_req && output_freq <= thresh_freq_cfg;
	dscs_stop_e cand;
	assign cand = stop_in_act ? input_stop_type_cfg :
		thr_hit ? thresh_stop_type_cfg : DSCS_STOP_NONE;

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			run_cmd <= 1'b0;
			reverse_dir <= 1'b0;
			target_freq <= FREQ_ZERO;
			jog_active <= 1'b0;
			fast_ramp_req <= 1'b0;
			stop_method <= DSCS_STOP_NONE;
			stop_req <= 1'b0;
		end else begin
			run_cmd <= en_s && (dir_req || jog_prev_reg) && stop_method == DSCS_STOP_NONE;
			reverse_dir <= (fwd_req ? 1'b0 : rev_req) ^ (neg_sum && !clamp_sum_cfg);
			target_freq <= tgt_next;
			jog_active <= jog_prev_reg;
			fast_ramp_req <= jog_prev_reg;
			if (dir_req && !stop_in_act)
				stop_method <= DSCS_STOP_NONE;
			else if (cand > stop_method || (stop_in_act && stop_method != input_stop_type_cfg
				&& stop_method == DSCS_STOP_NONE))
				stop_method <= cand;
			stop_req <= cand != DSCS_STOP_NONE || (stop_method != DSCS_STOP_NONE && !dir_req);
		end
	end

	a_fwd_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
		fwd_req && !(neg_sum && !clamp_sum_cfg) |=> !reverse_dir)
		else $error("reverse asserted with forward request");
	a_jog_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
		jog_prev_reg |=> jog_active && fast_ramp_req && target_freq == $past(jog_spd))
		else $error("jog without fast ramp");
	a_keypad_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
		keypad_mode_cfg |-> !stop_in_act)
		else $error("stop input active in keypad mode");
	a_dn_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
		run_cmd && dn_l && step_cnt_reg == '0 && $past(run_cmd) |=> ud_reg <= $past(ud_reg))
		else $error("speed rose with decrease held");
	a_cap_time: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(setpt_valid_reg) |-> cap_cnt_reg == 22'(CAPTURE_CYC))
		else $error("setpoint taken before qualification");
	a_setpt_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
		!dir_req && !cap_l |=> !setpt_valid_reg)
		else $error("setpoint kept after direction removed");
	a_target_clamp: assert property (@(posedge sys_clk) disable iff (!resetn)
		!jog_prev_reg && !ud_mode && !setpt_valid_reg |=> target_freq <= $past(high_speed_cfg))
		else $error("target above high speed");
	a_stop_rank: assert property (@(posedge sys_clk) disable iff (!resetn)
		stop_method != DSCS_STOP_NONE && !dir_req && !stop_in_act |=>
		stop_method >= $past(stop_method))
		else $error("stop method dropped in rank");
endmodule // dscs_top

`default_nettype wire

/* File: verif/dscs_plc.sv */
// plc-like model of the field wiring: drives the five logic inputs of the selector
// assumes the bench calls drive() and that sys_clk runs without pause
`default_nettype none

module dscs_plc (
	input wire logic sys_clk,
	output logic run_enable_input,
	output logic run_forward_input,
	output logic assignable_input_a,
	output logic assignable_input_b,
	output logic auto_run_input
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		run_enable_input = 1'b0;
		run_forward_input = 1'b0;
		assignable_input_a = 1'b0;
		assignable_input_b = 1'b0;
		auto_run_input = 1'b0;
	end

	// pins move just after an edge, never on it, so no race with the synchroniser
	// input one is always run enable and input two always run forward
	task automatic drive(input logic [4:0] pins);
		@(posedge sys_clk);
		#2;
		run_enable_input = pins[4];
		run_forward_input = pins[3];
		assignable_input_a = pins[2];
		assignable_input_b = pins[1];
		auto_run_input = pins[0];
	endtask
endmodule // dscs_plc

`default_nettype wire

/* File: verif/test_dscs_top.sv */
// self-checking bench for the drive speed command selector
// assumes the plc model in dscs_plc and the package dscs_pkg; pin vector is
// {enable, forward, input a, input b, auto run}
`default_nettype none

`define chk(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module test_dscs_top import dscs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, resetn;
	wire logic run_enable_input, run_forward_input, assignable_input_a, assignable_input_b;
	wire logic auto_run_input;
	logic [AW-1:0] voltage_reference_input, current_reference_input;
	logic three_wire_cfg, keypad_mode_cfg, three_presets_cfg, updown_memory_cfg;
	logic auto_manual_en_cfg, ref1_is_current_cfg, invert_current_cfg, clamp_sum_cfg;
	logic stop_active_high_cfg, thresh_stop_en_cfg;
	dscs_fn_e func_a_cfg, func_b_cfg;
	dscs_range_e current_range_cfg;
	dscs_stop_e input_stop_type_cfg, thresh_stop_type_cfg, stop_method;
	logic [7:0] current_x_cfg;
	logic [FW-1:0] thresh_freq_cfg, jog_speed_cfg, preset1_cfg, preset2_cfg, preset3_cfg;
	logic [FW-1:0] low_speed_cfg, high_speed_cfg, output_freq, target_freq;
	logic run_cmd, reverse_dir, jog_active, fast_ramp_req, stop_req;
	logic [FW-1:0] exp_f [4];
	int n_mismatch = 0;
	int n_compared = 0;

	dscs_plc u_plc (.sys_clk, .run_enable_input, .run_forward_input, .assignable_input_a,
		.assignable_input_b, .auto_run_input);

	dscs_top u_dut (.sys_clk, .resetn, .run_enable_input, .run_forward_input,
		.assignable_input_a, .assignable_input_b, .auto_run_input, .voltage_reference_input,
		.current_reference_input, .three_wire_cfg, .keypad_mode_cfg, .func_a_cfg, .func_b_cfg,
		.three_presets_cfg, .updown_memory_cfg, .auto_manual_en_cfg, .ref1_is_current_cfg,
		.current_range_cfg, .current_x_cfg, .invert_current_cfg, .clamp_sum_cfg,
		.stop_active_high_cfg, .thresh_stop_en_cfg, .thresh_freq_cfg, .input_stop_type_cfg,
		.thresh_stop_type_cfg, .jog_speed_cfg, .preset1_cfg, .preset2_cfg, .preset3_cfg,
		.low_speed_cfg, .high_speed_cfg, .output_freq, .run_cmd, .reverse_dir, .target_freq,
		.jog_active, .fast_ramp_req, .stop_method, .stop_req);

	// ----------------------------------------
	// clock, waits and verdict
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// always leaves us 2 ns after an edge, so config writes never race the clock
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	// outputs follow a pin change within 6 edges (a held stop delays run_cmd and the +/- reset); 6 leaves no margin
	task automatic step(input logic [4:0] pins);
		u_plc.drive(pins);
		settle(6);
	endtask

	initial begin
		settle(100000);
		n_mismatch++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		{three_wire_cfg, keypad_mode_cfg, three_presets_cfg, updown_memory_cfg} = 4'h0;
		{auto_manual_en_cfg, ref1_is_current_cfg, invert_current_cfg, thresh_stop_en_cfg} = 4'h0;
		clamp_sum_cfg = 1'b1;
		stop_active_high_cfg = 1'b1;
		func_a_cfg = DSCS_FN_REVERSE;
		func_b_cfg = DSCS_FN_JOG;
		current_range_cfg = DSCS_MA_4_20;
		current_x_cfg = MA4_TENTHS;
		input_stop_type_cfg = DSCS_STOP_FAST;
		thresh_stop_type_cfg = DSCS_STOP_DC;
		thresh_freq_cfg = 12'h010;
		jog_speed_cfg = JOG_DEF;
		preset1_cfg = PRESET1_DEF;
		preset2_cfg = PRESET2_DEF;
		preset3_cfg = PRESET3_DEF;
		low_speed_cfg = 12'h020;
		high_speed_cfg = 12'h1F4;
		output_freq = FREQ_ZERO;
		voltage_reference_input = 10'h000;
		current_reference_input = 10'h000;
		settle(5);
		resetn = 1'b1;
		settle(2);
		`chk(run_cmd, 1'b0)
		`chk(stop_method, DSCS_STOP_NONE)
		// forward run; zero reference sits at low speed
		step(5'h18);
		`chk(run_cmd, 1'b1)
		`chk(target_freq, low_speed_cfg)
		step(5'h08);
		`chk(run_cmd, 1'b0)
		// reverse as a level, forward wins a tie
		step(5'h14);
		`chk({run_cmd, reverse_dir}, 2'h3)
		step(5'h1C);
		`chk(reverse_dir, 1'b0)
		step(5'h10);
		`chk(run_cmd, 1'b0)
		// three-wire: a pulse on the reverse input is remembered
		three_wire_cfg = 1'b1;
		step(5'h14);
		step(5'h10);
		`chk(reverse_dir, 1'b1)
		step(5'h00);
		three_wire_cfg = 1'b0;
		// jog for exactly as long as input b is high
		step(5'h1A);
		`chk({jog_active, fast_ramp_req}, 2'h3)
		`chk(target_freq, JOG_DEF)
		step(5'h18);
		`chk(jog_active, 1'b0)
		// three presets; the top one is limited by high speed
		func_a_cfg = DSCS_FN_PRESET;
		func_b_cfg = DSCS_FN_PRESET;
		three_presets_cfg = 1'b1;
		high_speed_cfg = 12'h078;
		exp_f = '{FREQ_ZERO, PRESET1_DEF, PRESET2_DEF, 12'h078};
		for (int i = 1; i < 4; i++) begin
			step({2'b11, i[0], i[1], 1'b0});
			`chk(target_freq, exp_f[i])
		end
		three_presets_cfg = 1'b0;
		func_b_cfg = DSCS_FN_NONE;
		step(5'h1C);
		`chk(target_freq, PRESET1_DEF)
		// every current range at full scale, voltage at zero
		func_a_cfg = DSCS_FN_NONE;
		current_reference_input = AI_FULL;
		exp_f = '{12'h078, 12'h078, 12'h020, 12'h078};
		for (int r = 0; r < 4; r++) begin
			current_range_cfg = dscs_range_e'(r);
			step(5'h18);
			`chk(target_freq, exp_f[r])
		end
		current_range_cfg = DSCS_MA_0_20;
		voltage_reference_input = AI_FULL;
		step(5'h18);
		`chk(target_freq, high_speed_cfg)
		// inverted current: clamp gives low speed, no clamp turns round
		voltage_reference_input = 10'h000;
		invert_current_cfg = 1'b1;
		step(5'h18);
		`chk({reverse_dir, target_freq}, {1'b0, low_speed_cfg})
		clamp_sum_cfg = 1'b0;
		step(5'h18);
		`chk(reverse_dir, 1'b1)
		invert_current_cfg = 1'b0;
		clamp_sum_cfg = 1'b1;
		// auto/manual: manual takes voltage, auto takes current and auto run
		auto_manual_en_cfg = 1'b1;
		voltage_reference_input = AI_FULL;
		current_reference_input = 10'h000;
		step(5'h18);
		`chk(target_freq, high_speed_cfg)
		step(5'h11);
		`chk({run_cmd, target_freq}, {1'b1, low_speed_cfg})
		auto_manual_en_cfg = 1'b0;
		step(5'h11);
		`chk(run_cmd, 1'b0)
		// a capture pulse far shorter than the qualifying time must not freeze the reference
		func_a_cfg = DSCS_FN_CAPTURE;
		voltage_reference_input = 10'h000;
		step(5'h1C);
		step(5'h18);
		voltage_reference_input = AI_FULL;
		settle(6);
		`chk(target_freq, high_speed_cfg)
		// stop input: each method, active low, ignored from the keypad
		func_a_cfg = DSCS_FN_STOP;
		stop_active_high_cfg = 1'b0;
		for (int k = 1; k < 4; k++) begin
			input_stop_type_cfg = dscs_stop_e'(k);
			step(5'h18);
			`chk({stop_req, stop_method}, {1'b1, dscs_stop_e'(k)})
			step(5'h1C);
		end
		keypad_mode_cfg = 1'b1;
		step(5'h18);
		`chk(stop_req, 1'b0)
		// threshold stop, also from the keypad; a later freewheel outranks it
		func_a_cfg = DSCS_FN_NONE;
		thresh_stop_en_cfg = 1'b1;
		output_freq = 12'h020;
		step(5'h10);
		`chk(stop_req, 1'b0)
		output_freq = 12'h008;
		settle(6);
		`chk({stop_req, stop_method}, {1'b1, DSCS_STOP_DC})
		keypad_mode_cfg = 1'b0;
		stop_active_high_cfg = 1'b1;
		input_stop_type_cfg = DSCS_STOP_FREE;
		func_a_cfg = DSCS_FN_STOP;
		step(5'h14);
		`chk(stop_method, DSCS_STOP_FREE)
		// +/- speed without memory, starting from zero
		func_a_cfg = DSCS_FN_SPEED_UP;
		func_b_cfg = DSCS_FN_SPEED_DOWN;
		thresh_stop_en_cfg = 1'b0;
		output_freq = FREQ_ZERO;
		low_speed_cfg = FREQ_ZERO;
		step(5'h00);
		step(5'h18);
		`chk(target_freq, FREQ_ZERO)
		step(5'h1C);
		settle(8 * RAMP_STEP_CYC);
		`chk(target_freq inside {[12'h007 : 12'h00A]}, 1'b1)
		step(5'h18);
		settle(2 * RAMP_STEP_CYC);
		`chk(target_freq inside {[12'h007 : 12'h00A]}, 1'b1)
		// with memory a stop and restart keeps the reached speed
		updown_memory_cfg = 1'b1;
		step(5'h10);
		step(5'h18);
		`chk(target_freq inside {[12'h007 : 12'h00A]}, 1'b1)
		updown_memory_cfg = 1'b0;
		step(5'h1E);
		settle(3 * RAMP_STEP_CYC);
		`chk(target_freq inside {[12'h003 : 12'h007]}, 1'b1)
		step(5'h1A);
		settle(10 * RAMP_STEP_CYC);
		`chk(target_freq, FREQ_ZERO)
		complete_run();
	end
endmodule // test_dscs_top

`default_nettype wire
